// [hw/mmpm_regs.v]
/*
 * Management register bank of a passive loopback module: two-wire slave
 * with page select, power mode decision, alert and present pins, monitors.
 * Assumes clk_sys is far faster than the serial clock, sensor words come
 * from logic on clk_sys, and pins are pulled up outside the module.
 */
`include "mmpm_defines.vh"
`default_nettype none

module mmpm_regs #(
    parameter [7:0] MODULE_ID = 8'h5a // Arbitrary identifier value
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // Two-wire serial pins
    input wire scl,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe_n,
    // Low speed pins
    input wire module_select_n,
    input wire low_power_request_pin,
    output wire fault_alert_n_out,
    output wire fault_alert_n_oe_n,
    output wire module_present_n,
    // Internal fault and sensors
    input wire fault_req,
    input wire [15:0] temp_value,
    input wire [15:0] supply_value,
    // Power and indication
    output reg low_power_q,
    output reg [7:0] heat_level_q,
    output reg led_green_q,
    output reg led_orange_q,
    output reg temp_valid_q
);

    reg [2:0] scl_s_q;
    reg [2:0] sda_s_q;
    reg [1:0] sel_s_q;
    reg [1:0] lp_s_q;
    reg [2:0] state_q;
    reg [2:0] next_q;
    reg [3:0] bitcnt_q;
    reg [7:0] shift_q;
    reg [7:0] tx_q;
    reg [7:0] addr_q;
    reg [7:0] page_q;
    reg [7:0] pwr_ctrl_q;
    reg alert_test_q;
    reg rw_q;
    reg drv_low_q;
    reg [15:0] temp_snap_q;
    reg [15:0] volt_snap_q;
    reg [7:0] mem_lo [0:127];
    reg [7:0] mem_up [0:511];

    wire scl_rise;
    wire scl_fall;
    wire start_ev;
    wire stop_ev;
    wire sda_s;
    wire selected;
    wire lp_pin;
    wire alert_drive;
    wire low_power_d;
    reg [7:0] rd_data;

    // Address after one data word, rolling within the same page
    function [7:0] next_addr(input [7:0] a);
        begin
            next_addr = {a[7], a[6:0] + 7'h01};
        end
    endfunction

    // Byte returned for a read at the current address on the selected page;
    // a process, so that page, pins, snapshots and memories all wake it
    always @* begin
        rd_data = 8'h00;
        if (!addr_q[7]) begin
            case (addr_q[6:0])
                `MMPM_OFF_ID: rd_data = MODULE_ID;
                `MMPM_OFF_TEMP_HI: rd_data = temp_snap_q[15:8];
                `MMPM_OFF_TEMP_LO: rd_data = temp_snap_q[7:0];
                `MMPM_OFF_VOLT_HI: rd_data = volt_snap_q[15:8];
                `MMPM_OFF_VOLT_LO: rd_data = volt_snap_q[7:0];
                `MMPM_OFF_PWR_CTRL: rd_data = pwr_ctrl_q;
                `MMPM_OFF_PAGE_SEL: rd_data = page_q;
                default: rd_data = mem_lo[addr_q[6:0]];
            endcase
        end else if (page_q == `MMPM_PAGE_ID && addr_q == `MMPM_OFF_UP_ID) begin
            rd_data = MODULE_ID;
        end else if (page_q == `MMPM_PAGE_TEST && addr_q == `MMPM_OFF_RST_PIN) begin
            rd_data = `MMPM_RST_PIN_READ;
        end else if (page_q == `MMPM_PAGE_TEST && addr_q == `MMPM_OFF_LP_PIN) begin
            rd_data = {7'h00, lp_pin};
        end else if (page_q == `MMPM_PAGE_TEST && addr_q == `MMPM_OFF_ALERT) begin
            rd_data = {7'h00, ~alert_drive};
        end else if (page_q <= `MMPM_PAGE_LAST) begin
            rd_data = mem_up[{page_q[1:0], addr_q[6:0]}];
        end
    end

    // Pin synchronisers; edge detection reads only second and third stages
    always @(posedge clk_sys) begin
        if (rst) begin
            scl_s_q <= 3'h7;
            sda_s_q <= 3'h7;
            sel_s_q <= 2'h3;
            lp_s_q <= 2'h0;
        end else begin
            scl_s_q <= {scl_s_q[1:0], scl};
            sda_s_q <= {sda_s_q[1:0], sda_in};
            sel_s_q <= {sel_s_q[0], module_select_n};
            lp_s_q <= {lp_s_q[0], low_power_request_pin};
        end
    end

    // Bus events
    assign sda_s = sda_s_q[1];
    assign scl_rise = scl_s_q[1] & ~scl_s_q[2];
    assign scl_fall = ~scl_s_q[1] & scl_s_q[2];
    assign start_ev = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[1] & sda_s_q[2];
    assign stop_ev = scl_s_q[1] & scl_s_q[2] & sda_s_q[1] & ~sda_s_q[2];
    assign selected = ~sel_s_q[1];
    assign lp_pin = lp_s_q[1];

    // Open-drain pins: value low, enable active low when pulling
    assign sda_out = 1'b0;
    assign sda_oe_n = ~drv_low_q;
    assign alert_drive = fault_req | ~alert_test_q;
    assign fault_alert_n_out = 1'b0;
    assign fault_alert_n_oe_n = ~alert_drive;
    assign module_present_n = 1'b0;

    // Two-wire slave sequencer and register writes
    always @(posedge clk_sys) begin
        if (rst) begin
            state_q <= `MMPM_ST_IDLE;
            next_q <= `MMPM_ST_IDLE;
            bitcnt_q <= 4'h0;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            addr_q <= 8'h00;
            page_q <= `MMPM_RST_PAGE;
            pwr_ctrl_q <= `MMPM_RST_PWR_CTRL;
            alert_test_q <= `MMPM_RST_ALERT;
            rw_q <= 1'b0;
            drv_low_q <= 1'b0;
            temp_snap_q <= 16'h0000;
            volt_snap_q <= 16'h0000;
        end else if (start_ev) begin
            // Start or repeated start: snapshot monitors coherently
            state_q <= `MMPM_ST_DEV;
            bitcnt_q <= 4'h0;
            drv_low_q <= 1'b0;
            temp_snap_q <= temp_value;
            volt_snap_q <= supply_value;
        end else if (stop_ev) begin
            state_q <= `MMPM_ST_IDLE;
            drv_low_q <= 1'b0;
        end else if (scl_rise) begin
            case (state_q)
                `MMPM_ST_DEV, `MMPM_ST_WADDR, `MMPM_ST_WDATA: begin
                    shift_q <= {shift_q[6:0], sda_s};
                    bitcnt_q <= bitcnt_q + 4'h1;
                end
                `MMPM_ST_READ: begin
                    bitcnt_q <= bitcnt_q + 4'h1;
                end
                `MMPM_ST_MACK: begin
                    // Host ack asks for another byte, nack ends the read
                    state_q <= sda_s ? `MMPM_ST_IDLE : `MMPM_ST_RLOAD;
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (state_q)
                `MMPM_ST_DEV: begin
                    if (bitcnt_q == 4'h8) begin
                        if (shift_q[7:1] == `MMPM_DEV_ADDR && selected) begin
                            drv_low_q <= 1'b1;
                            rw_q <= shift_q[0];
                            next_q <= shift_q[0] ? `MMPM_ST_RLOAD : `MMPM_ST_WADDR;
                            state_q <= `MMPM_ST_ACK;
                        end else begin
                            state_q <= `MMPM_ST_IDLE;
                        end
                    end
                end
                `MMPM_ST_WADDR: begin
                    if (bitcnt_q == 4'h8) begin
                        addr_q <= shift_q;
                        drv_low_q <= 1'b1;
                        next_q <= `MMPM_ST_WDATA;
                        state_q <= `MMPM_ST_ACK;
                    end
                end
                `MMPM_ST_WDATA: begin
                    if (bitcnt_q == 4'h8) begin
                        addr_q <= next_addr(addr_q);
                        drv_low_q <= 1'b1;
                        next_q <= `MMPM_ST_WDATA;
                        state_q <= `MMPM_ST_ACK;
                        if (!addr_q[7]) begin
                            if (addr_q[6:0] == `MMPM_OFF_PWR_CTRL) begin
                                pwr_ctrl_q <= shift_q;
                            end else if (addr_q[6:0] == `MMPM_OFF_PAGE_SEL) begin
                                page_q <= shift_q;
                            end
                        end else if (page_q == `MMPM_PAGE_TEST &&
                                     addr_q == `MMPM_OFF_ALERT) begin
                            alert_test_q <= shift_q[0];
                        end
                    end
                end
                `MMPM_ST_ACK: begin
                    // Ack bit done: release, or turn straight into a read
                    bitcnt_q <= 4'h0;
                    if (next_q == `MMPM_ST_RLOAD) begin
                        tx_q <= {rd_data[6:0], 1'b0};
                        drv_low_q <= ~rd_data[7];
                        addr_q <= next_addr(addr_q);
                        state_q <= `MMPM_ST_READ;
                    end else begin
                        drv_low_q <= 1'b0;
                        state_q <= next_q;
                    end
                end
                `MMPM_ST_READ: begin
                    if (bitcnt_q == 4'h8) begin
                        drv_low_q <= 1'b0;
                        state_q <= `MMPM_ST_MACK;
                    end else begin
                        drv_low_q <= ~tx_q[7];
                        tx_q <= {tx_q[6:0], 1'b0};
                    end
                end
                `MMPM_ST_RLOAD: begin
                    bitcnt_q <= 4'h0;
                    tx_q <= {rd_data[6:0], 1'b0};
                    drv_low_q <= ~rd_data[7];
                    addr_q <= next_addr(addr_q);
                    state_q <= `MMPM_ST_READ;
                end
                default: begin
                end
            endcase
        end
    end

    // Plain byte storage; read-only lower bytes and page 00 never written
    always @(posedge clk_sys) begin
        if (!rst && !start_ev && !stop_ev && scl_fall &&
            state_q == `MMPM_ST_WDATA && bitcnt_q == 4'h8) begin
            if (!addr_q[7]) begin
                if (addr_q[6:0] > `MMPM_OFF_RO_LAST) begin
                    mem_lo[addr_q[6:0]] <= shift_q;
                end
            end else if (page_q != `MMPM_PAGE_ID && page_q <= `MMPM_PAGE_LAST) begin
                mem_up[{page_q[1:0], addr_q[6:0]}] <= shift_q;
            end
        end
    end

    // Power mode decision and its effects
    assign low_power_d = pwr_ctrl_q[`MMPM_BIT_OVERRIDE] ?
                         pwr_ctrl_q[`MMPM_BIT_SELECT] : lp_pin;

    always @(posedge clk_sys) begin
        if (rst) begin
            low_power_q <= 1'b0;
            heat_level_q <= 8'h00;
            led_green_q <= 1'b0;
            led_orange_q <= 1'b0;
            temp_valid_q <= 1'b0;
        end else begin
            low_power_q <= low_power_d;
            heat_level_q <= low_power_d ? 8'h00 : mem_lo[`MMPM_OFF_HEAT];
            led_green_q <= ~low_power_d;
            led_orange_q <= low_power_d;
            temp_valid_q <= ($signed(temp_value) >= $signed(`MMPM_TEMP_MIN)) &&
                            ($signed(temp_value) <= $signed(`MMPM_TEMP_MAX));
        end
    end

endmodule

`default_nettype wire

// [hw/mmpm_defines.vh]
/*
 * Constants for the module management register bank: two-wire slave
 * address, byte offsets, field positions, reset values, temperature limits.
 * Assumes inclusion by the design file only; holds definitions only.
 */
`ifndef MMPM_DEFINES_VH
`define MMPM_DEFINES_VH

// Two-wire device address (upper seven bits)
`define MMPM_DEV_ADDR 7'h50

// Lower page byte offsets
`define MMPM_OFF_ID 7'h00
`define MMPM_OFF_TEMP_HI 7'h16
`define MMPM_OFF_TEMP_LO 7'h17
`define MMPM_OFF_VOLT_HI 7'h1a
`define MMPM_OFF_VOLT_LO 7'h1b
`define MMPM_OFF_RO_LAST 7'h55
`define MMPM_OFF_PWR_CTRL 7'h5d
`define MMPM_OFF_HEAT 7'h62
`define MMPM_OFF_PAGE_SEL 7'h7f

// Upper page offsets (full byte address)
`define MMPM_OFF_UP_ID 8'h80
`define MMPM_OFF_RST_PIN 8'h91
`define MMPM_OFF_LP_PIN 8'h92
`define MMPM_OFF_ALERT 8'h93

// Upper page numbers
`define MMPM_PAGE_ID 8'h00
`define MMPM_PAGE_TEST 8'h02
`define MMPM_PAGE_LAST 8'h03

// Power mode control fields
`define MMPM_BIT_OVERRIDE 0
`define MMPM_BIT_SELECT 1

// Reset values
`define MMPM_RST_PWR_CTRL 8'h00
`define MMPM_RST_PAGE 8'h00
`define MMPM_RST_ALERT 1'b1
`define MMPM_RST_PIN_READ 8'h01

// Valid temperature window, 1/256 degree units (-40 C and +125 C)
`define MMPM_TEMP_MIN 16'hd800
`define MMPM_TEMP_MAX 16'h7d00

// Slave state codes
`define MMPM_ST_IDLE 3'h0
`define MMPM_ST_DEV 3'h1
`define MMPM_ST_WADDR 3'h2
`define MMPM_ST_WDATA 3'h3
`define MMPM_ST_ACK 3'h4
`define MMPM_ST_READ 3'h5
`define MMPM_ST_MACK 3'h6
`define MMPM_ST_RLOAD 3'h7

`endif

// [tb/mmpm_regs_monitor.sv]
/* Checker for the management register bank: pin levels, power indication,
   temperature flag and serial bit timing. Assumes one clk_sys domain and a
   bind onto mmpm_regs. */
`default_nettype none
module mmpm_regs_monitor (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Serial and low speed pins
    input wire logic scl,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic module_select_n,
    input wire logic fault_alert_n_out,
    input wire logic fault_alert_n_oe_n,
    input wire logic module_present_n,
    // Internal inputs and outputs
    input wire logic fault_req,
    input wire logic [15:0] temp_value,
    input wire logic low_power_q,
    input wire logic [7:0] heat_level_q,
    input wire logic led_green_q,
    input wire logic led_orange_q,
    input wire logic temp_valid_q
);
    timeunit 1ns;
    timeprecision 100ps;
    // Reading inside -40..+125 C in 1/256 degree steps
    wire t_ok = $signed(temp_value) >= -10240 && $signed(temp_value) <= 32000;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    present_low_a: assert property (module_present_n == 1'b0)
        else $error("present output not low");
    alert_fault_a: assert property (fault_req |-> !fault_alert_n_oe_n)
        else $error("alert not pulled on fault");
    od_level_a: assert property (!sda_out && !fault_alert_n_out)
        else $error("open drain value not low");
    low_dark_a: assert property (
        low_power_q |-> heat_level_q == 8'h00 && led_orange_q && !led_green_q)
        else $error("low power still dissipating");
    high_green_a: assert property (
        !low_power_q && !$past(rst) && !$past(rst, 2) |-> led_green_q && !led_orange_q)
        else $error("high power without green");
    temp_flag_a: assert property (
        !$past(rst) && !$past(rst, 2) |-> temp_valid_q == $past(t_ok))
        else $error("temperature flag wrong");
    sel_quiet_a: assert property (module_select_n [*6] |-> sda_oe_n)
        else $error("data driven while deselected");
    bit_hold_a: assert property (scl [*3] |-> $stable(sda_oe_n))
        else $error("data changed while clock high");
    // Main scenarios
    cover property (low_power_q ##1 !low_power_q);
    cover property (!sda_oe_n);
    cover property (!temp_valid_q ##1 temp_valid_q);
endmodule
bind mmpm_regs mmpm_regs_monitor i_mon (.*);
`default_nettype wire

// [tb/mmpm_host.sv]
/* Two-wire host master model: start, stop, byte transfers and framed
   register accesses. Assumes SDA is a pulled-up wired-and in the bench. */
`default_nettype none
module mmpm_host (
    // Clock for result strobes
    input wire logic clk_sys,
    // Serial pins
    output logic scl,
    output logic sda_m,
    input wire logic sda,
    // Received byte strobe
    output logic stb,
    output logic [7:0] rd_v
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle bus: both lines released, clock stands high
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
        stb = 1'b0;
        rd_v = 8'h00;
    end
    // Data falls while clock high
    task start();
        sda_m = 1'b1;
        #40 scl = 1'b1;
        #40 sda_m = 1'b0;
        #40 scl = 1'b0;
    endtask
    // Data rises while clock high
    task stop();
        sda_m = 1'b0;
        #40 scl = 1'b1;
        #40 sda_m = 1'b1;
        #40;
    endtask
    // Data set in clock low, sampled late in clock high
    task bit_io(input logic b, output logic r);
        sda_m = b;
        #40 scl = 1'b1;
        #80 r = sda;
        scl = 1'b0;
        #40;
    endtask
    // Eight bits out, msb first, then the ack slot
    task tx(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(v[i], r);
        end
        bit_io(1'b1, ack);
    endtask
    // Eight bits in, strobe the byte, then ack or nack
    task rx(input logic last, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, v[i]);
        end
        @(posedge clk_sys);
        #1 rd_v = v;
        stb = 1'b1;
        @(posedge clk_sys);
        #1 stb = 1'b0;
        bit_io(last, r);
    endtask
    // Register write of the given bytes from an offset
    task wr(input logic [7:0] off, input logic [7:0] d[$]);
        logic a;
        start();
        tx(8'ha0, a);
        tx(off, a);
        foreach (d[i]) begin
            tx(d[i], a);
        end
        stop();
    endtask
    // Random read of n bytes, nack on the last
    task rd(input logic [7:0] off, input int n);
        logic a;
        logic [7:0] v;
        start();
        tx(8'ha0, a);
        tx(off, a);
        start();
        tx(8'ha1, a);
        for (int i = 0; i < n; i++) begin
            rx(i == n - 1, v);
        end
        stop();
    endtask
endmodule
`default_nettype wire

// [tb/mmpm_regs_tb.sv]
/* Self-checking bench for the management register bank: power decision,
   pin readback, alert drive, page map, monitors and address refusal.
   Assumes the host model and checker are compiled before it. */
`default_nettype none
module mmpm_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] ID = 8'h3c; // Arbitrary identifier value
    logic clk_sys = 1'b0, rst = 1'b1, sel_n = 1'b0, lp_pin = 1'b0, fault = 1'b0;
    logic scl, sda_m, sda, sda_out, sda_oe_n, hstb, alert_out, alert_oe_n, present_n;
    logic lp_q, green, orange, tvalid, ob_s = 1'b0;
    logic [7:0] heat, hv;
    logic [15:0] temp = 16'h1900, volt = 16'h8000;
    logic [15:0] tw[4] = '{16'hd7ff, 16'hd800, 16'h7d00, 16'h7d01};
    logic [10:0] ob_v = 11'h000;
    logic [10:0] exq[$];
    logic [31:0] seed = 32'h879ec68d;
    int n_mismatch = 0, checks_done = 0, cyc = 0;
    always #10 clk_sys = ~clk_sys;
    // Pulled-up data line, low when either side pulls
    assign sda = sda_m & (sda_oe_n | sda_out);
    mmpm_host i_host (.clk_sys(clk_sys), .scl(scl), .sda_m(sda_m), .sda(sda), .stb(hstb),
        .rd_v(hv));
    mmpm_regs #(.MODULE_ID(ID)) i_dut (.clk_sys(clk_sys), .rst(rst), .scl(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .module_select_n(sel_n),
        .low_power_request_pin(lp_pin), .fault_alert_n_out(alert_out),
        .fault_alert_n_oe_n(alert_oe_n), .module_present_n(present_n), .fault_req(fault),
        .temp_value(temp), .supply_value(volt), .low_power_q(lp_q), .heat_level_q(heat),
        .led_green_q(green), .led_orange_q(orange), .temp_valid_q(tvalid));
    // Oldest note against each result that appears
    always @(posedge clk_sys) begin
        if (hstb || ob_s) begin
            logic [10:0] got, e;
            got = hstb ? {3'h0, hv} : ob_v;
            e = exq.size() ? exq.pop_front() : 11'h7ff;
            checks_done++;
            if (got !== e) begin
                n_mismatch++;
                $display("unexpected %s: expected %h seen %h",
                         hstb ? "read byte" : "pin state", e, got);
            end
        end
    end
    function logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // Hand a port snapshot to the watcher
    task look(input logic [10:0] v);
        tick(1);
        ob_v = v;
        ob_s = 1'b1;
        tick(1);
        ob_s = 1'b0;
    endtask
    task rd1(input logic [7:0] off, input logic [7:0] e);
        exq.push_back({3'h0, e});
        i_host.rd(off, 1);
    endtask
    task rd2(input logic [7:0] off, input logic [15:0] e);
        exq.push_back({3'h0, e[15:8]});
        exq.push_back({3'h0, e[7:0]});
        i_host.rd(off, 2);
    endtask
    task conclude();
        if (exq.size() != 0) n_mismatch++;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Hang guard: about twice the cycles the whole sequence needs
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            conclude();
        end
    end
    // Main sequence
    initial begin
        logic [7:0] h, a, b;
        logic k;
        tick(6);
        rst = 1'b0;
        tick(4);
        rd1(8'd93, 8'h00);
        h = rnd();
        i_host.wr(8'd98, '{h});
        for (int i = 0; i < 8; i++) begin
            tick(1);
            lp_pin = i[2];
            i_host.wr(8'd93, '{{6'h0, i[0], i[1]}});
            tick(8);
            k = i[1] ? i[0] : i[2];
            exq.push_back({k, !k, k, k ? 8'h00 : h});
            look({lp_q, green, orange, heat});
        end
        rd1(8'd93, 8'h03);
        rd1(8'd0, ID);
        i_host.wr(8'd0, '{8'hff});
        rd1(8'd0, ID);
        a = rnd();
        b = rnd();
        i_host.wr(8'd100, '{a});
        rd1(8'd100, a);
        // Byte 85 is the last read-only one, byte 86 the first writable one
        i_host.wr(8'd85, '{a, b});
        rd1(8'd86, b);
        rd1(8'd127, 8'h00);
        rd1(8'd128, ID);
        tick(1);
        temp = {rnd(), rnd()};
        volt = {rnd(), rnd()};
        rd2(8'd22, temp);
        rd2(8'd26, volt);
        foreach (tw[j]) begin
            tick(1);
            temp = tw[j];
            tick(3);
            exq.push_back({10'h0, $signed(tw[j]) >= -10240 && $signed(tw[j]) <= 32000});
            look({10'h0, tvalid});
        end
        i_host.wr(8'd127, '{8'h02});
        rd1(8'd127, 8'h02);
        for (int i = 0; i < 2; i++) begin
            tick(1);
            lp_pin = i[0];
            tick(4);
            rd1(8'd146, {7'h0, i[0]});
            i_host.wr(8'd147, '{{7'h0, i[0]}});
            exq.push_back({10'h0, i[0]});
            look({10'h0, alert_oe_n});
        end
        // Let the alert pin settle after the fault moves, then snapshot it
        tick(1);
        fault = 1'b1;
        tick(1);
        exq.push_back(11'h000);
        look({10'h0, alert_oe_n});
        fault = 1'b0;
        tick(1);
        exq.push_back(11'h001);
        look({10'h0, alert_oe_n});
        a = rnd();
        b = rnd();
        i_host.wr(8'd255, '{a, b});
        rd2(8'd255, {a, b});
        rd1(8'd128, b);
        i_host.wr(8'd127, '{8'h03});
        i_host.wr(8'd200, '{a});
        rd1(8'd200, a);
        for (int i = 0; i < 3; i++) begin
            tick(1);
            sel_n = (i == 0);
            tick(4);
            i_host.start();
            i_host.tx(i == 1 ? 8'ha2 : 8'ha0, k);
            i_host.stop();
            exq.push_back({10'h0, i != 2});
            look({10'h0, k});
        end
        tick(20);
        conclude();
    end
endmodule
`default_nettype wire
